// File: hw/mca_ctrl.v
// Purpose: Dual-slope conversion sequencer, frequency gate timer and
//          LCD annunciator decode of an auto-ranging meter
// Assumes: One 50 MHz clock, synchronous active-high reset, classic
//          Wishbone slave for the mode, range and function state
// Notes:   Phase lengths and gate periods are parameters so a bench can
//          run them short; the register map is local to this block
//
// Sequencer behaviour
// The four phase outputs are levels taken straight from a one-hot
// Register, so the analog switches never see a decode glitch.
// Each phase counts its own cycles and hands over when the count
// Reaches its length; the next phase starts with the counter at zero.
// The length is chosen every cycle from the current mode, so a mode
// Write in mid-phase takes hold at once rather than next conversion.
// Because the end test is a greater-or-equal compare, a phase that is
// Already longer than its new length ends on the very next edge.
// That trades one clipped conversion for never stalling a full phase.
// The done pulse follows the last run-down cycle by one clock.
//
// Speed-up behaviour
// Software writes the range-changed bit when it moves the range and
// The stable bit once readings settle; if both arrive together the
// Range change wins, so a settle cannot hide a fresh range move.
// The fast lengths are divided at elaboration, so no divider is built;
// Lengths that are not multiples of the factor are truncated.
// Continuity and diode timing always wins over the fast cycle.
// Leaving the settling flag set outside the qualifying modes is
// Harmless: the fast paths also look at the mode and auto flags.
//
// Frequency gate
// The gate timer is held at zero outside frequency mode, so entering
// The mode always starts a full gate period.
// A range write mid-period shortens or stretches only that period.
//
// Annunciator decode
// All symbols are decoded from the stored mode, range, unit and
// Function flags, then registered once so the glass driver sees
// Clean levels one cycle after a register write.
// Range codes with no prefix simply light no prefix segment.
//
// Limitations
// Capacitance and temperature run the normal conversion timing;
// Per-range capacitance times are left to the far side.
// Only byte lanes zero and one reach the configuration registers.
//
// Overview of operation
// - Mode symbols: continuity, diode, hertz, farad
// - DC lit for DC voltage or current
// - AC lit for AC voltage or current
// - Auto when auto ranging, else fixed range
// - Hold symbol while hold is active
// - Offset reference symbol while relative active
// - Max/min symbol when either hold active
// - Capacitance: one prefix milli, micro or nano
// - Milli2 for millivolt or milliamp ranges
// - Micro2 for microamp current ranges
// - Resistance: mega or kilo prefix by range
// - Temperature: exactly one of Celsius, Fahrenheit
// - Power-off symbol when auto power-off enabled
// - RS232 symbol when serial output enabled
// - Four phases in fixed order
// - Normal phases 20, 20, 100, 110 ms
// - Continuity/diode phases 4, 4, 20, 22 ms
// - Auto DCV/ohm settling runs five times faster
// - Lowest frequency range cycles every 0.5 s
// - Upper frequency ranges cycle every 1.05 s
// - Auto frequency settling runs ten times faster
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "mca_defines.vh"

module mca_ctrl #(
	parameter [31:0] P_SETTLE_CYC   = `MCA_SETTLE_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_ZERO_CYC     = `MCA_ZERO_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_INT_CYC      = `MCA_INT_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_RUN_CYC      = `MCA_RUN_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_SETTLE_S_CYC = `MCA_SETTLE_S_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_ZERO_S_CYC   = `MCA_ZERO_S_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_INT_S_CYC    = `MCA_INT_S_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_RUN_S_CYC    = `MCA_RUN_S_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_FR_LOW_CYC   = `MCA_FR_LOW_MS * `MCA_CLK_KHZ,
	parameter [31:0] P_FR_UP_CYC    = `MCA_FR_UP_MS * `MCA_CLK_KHZ
) (
	input  wire                      clk_i,
	input  wire                      rst_i,
	input  wire                      wb_cyc_i,
	input  wire                      wb_stb_i,
	input  wire                      wb_we_i,
	input  wire [4:0]                wb_adr_i,
	input  wire [3:0]                wb_sel_i,
	input  wire [31:0]               wb_dat_i,
	output reg  [31:0]               wb_dat_o,
	output reg                       wb_ack_o,
	output wire                      zero_settle_o,
	output wire                      auto_zero_o,
	output wire                      ramp_up_o,
	output wire                      rundown_o,
	output reg                       conv_done_o,
	output reg                       freq_cycle_o,
	output reg  [`MCA_AN_WIDTH-1:0]  annun_o
);

	// One-hot phase codes
	localparam [3:0] PH_SETTLE = 4'b0001;
	localparam [3:0] PH_ZERO   = 4'b0010;
	localparam [3:0] PH_INT    = 4'b0100;
	localparam [3:0] PH_RUN    = 4'b1000;

	// Sped-up counts, fixed at elaboration so no divider is built
	localparam [31:0] SETTLE_F = P_SETTLE_CYC / `MCA_FAST_DIV;
	localparam [31:0] ZERO_F   = P_ZERO_CYC / `MCA_FAST_DIV;
	localparam [31:0] INT_F    = P_INT_CYC / `MCA_FAST_DIV;
	localparam [31:0] RUN_F    = P_RUN_CYC / `MCA_FAST_DIV;
	localparam [31:0] FR_LOW_F = P_FR_LOW_CYC / `MCA_FREQ_DIV;
	localparam [31:0] FR_UP_F  = P_FR_UP_CYC / `MCA_FREQ_DIV;

	// Software-visible state
	reg  [9:0]  cfg;           // Mode, range, AC flag, current unit
	reg  [7:0]  flags;         // Function enables
	reg         settling;      // Range just changed, run fast

	// Sequencer state
	reg  [3:0]  phase;         // Current conversion phase
	reg  [3:0]  next_phase;    // Phase after this cycle
	reg  [31:0] phase_cnt;     // Cycles spent in current phase
	reg  [31:0] phase_len;     // Length of current phase
	reg  [31:0] freq_cnt;      // Cycles in current gate cycle
	reg  [31:0] freq_len;      // Length of gate cycle

	// Decoded fields
	wire [3:0]  mode    = cfg[3:0];
	wire [2:0]  range   = cfg[`MCA_CFG_RANGE_LSB+2:`MCA_CFG_RANGE_LSB];
	wire        ac      = cfg[`MCA_CFG_AC];
	wire [1:0]  unit    = cfg[`MCA_CFG_UNIT_LSB+1:`MCA_CFG_UNIT_LSB];
	wire        is_volt = (mode == `MCA_MODE_VOLT);
	wire        is_curr = (mode == `MCA_MODE_CURR);
	wire        is_ohm  = (mode == `MCA_MODE_OHM);
	wire        is_cap  = (mode == `MCA_MODE_CAP);
	wire        is_frq  = (mode == `MCA_MODE_FREQ);
	wire        is_temp = (mode == `MCA_MODE_TEMP);
	wire        is_vi   = is_volt | is_curr;
	wire        auto_on = flags[`MCA_FL_AUTO];
	wire        short_m = (mode == `MCA_MODE_CONT) | (mode == `MCA_MODE_DIODE);
	// Fast conversion only for auto DC volts or ohms
	wire        fast_cv = settling & auto_on & ((is_volt & ~ac) | is_ohm);
	// Fast gate only for auto frequency
	wire        fast_fr = settling & auto_on & is_frq;
	wire        phase_end = (phase_cnt >= phase_len - 32'h0000_0001);
	wire        freq_end  = (freq_cnt >= freq_len - 32'h0000_0001);

	// Bus decode
	wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        bus_wr  = bus_req & wb_we_i;
	wire [2:0]  word    = wb_adr_i[4:2];

	// Phase outputs straight from the one-hot state
	assign zero_settle_o = phase[0];
	assign auto_zero_o   = phase[1];
	assign ramp_up_o     = phase[2];
	assign rundown_o     = phase[3];

	// Length of the phase now running
	always @* begin
		phase_len = P_SETTLE_CYC;
		case (phase)
			PH_SETTLE: begin
				if (short_m) begin
					phase_len = P_SETTLE_S_CYC;
				end else if (fast_cv) begin
					phase_len = SETTLE_F;
				end else begin
					phase_len = P_SETTLE_CYC;
				end
			end
			PH_ZERO: begin
				if (short_m) begin
					phase_len = P_ZERO_S_CYC;
				end else if (fast_cv) begin
					phase_len = ZERO_F;
				end else begin
					phase_len = P_ZERO_CYC;
				end
			end
			PH_INT: begin
				if (short_m) begin
					phase_len = P_INT_S_CYC;
				end else if (fast_cv) begin
					phase_len = INT_F;
				end else begin
					phase_len = P_INT_CYC;
				end
			end
			PH_RUN: begin
				if (short_m) begin
					phase_len = P_RUN_S_CYC;
				end else if (fast_cv) begin
					phase_len = RUN_F;
				end else begin
					phase_len = P_RUN_CYC;
				end
			end
			default: begin
				phase_len = P_SETTLE_CYC;
			end
		endcase
	end

	// Next phase; a stray code falls back to zero settle
	always @* begin
		next_phase = phase;
		case (phase)
			PH_SETTLE: begin
				if (phase_end) next_phase = PH_ZERO;
			end
			PH_ZERO: begin
				if (phase_end) next_phase = PH_INT;
			end
			PH_INT: begin
				if (phase_end) next_phase = PH_RUN;
			end
			PH_RUN: begin
				if (phase_end) next_phase = PH_SETTLE;
			end
			default: begin
				next_phase = PH_SETTLE;
			end
		endcase
	end

	// Phase register and its cycle counter
	always @(posedge clk_i) begin
		if (rst_i) begin
			phase       <= PH_SETTLE;
			phase_cnt   <= 32'h0000_0000;
			conv_done_o <= 1'b0;
		end else begin
			phase       <= next_phase;
			// Mode change mid-phase: >= compare ends an overlong phase at once
			phase_cnt   <= (next_phase != phase) ? 32'h0000_0000 : phase_cnt + 32'h0000_0001;
			conv_done_o <= (phase == PH_RUN) & phase_end;
		end
	end

	// Gate cycle length of the frequency counter
	always @* begin
		if (range == 3'h0) begin
			freq_len = fast_fr ? FR_LOW_F : P_FR_LOW_CYC;
		end else begin
			freq_len = fast_fr ? FR_UP_F : P_FR_UP_CYC;
		end
	end

	// Frequency gate timer, held at zero outside frequency mode
	always @(posedge clk_i) begin
		if (rst_i) begin
			freq_cnt     <= 32'h0000_0000;
			freq_cycle_o <= 1'b0;
		end else if (!is_frq) begin
			freq_cnt     <= 32'h0000_0000;
			freq_cycle_o <= 1'b0;
		end else begin
			freq_cnt     <= freq_end ? 32'h0000_0000 : freq_cnt + 32'h0000_0001;
			freq_cycle_o <= freq_end;
		end
	end

	// Annunciator decode from mode, range and function state
	reg [`MCA_AN_WIDTH-1:0] next_annun;
	always @* begin
		next_annun = {`MCA_AN_WIDTH{1'b0}};
		next_annun[`MCA_AN_CONT]   = (mode == `MCA_MODE_CONT);
		next_annun[`MCA_AN_DIODE]  = (mode == `MCA_MODE_DIODE);
		next_annun[`MCA_AN_HZ]     = is_frq;
		next_annun[`MCA_AN_FARAD]  = is_cap;
		next_annun[`MCA_AN_DC]     = is_vi & ~ac;
		next_annun[`MCA_AN_AC]     = is_vi & ac;
		next_annun[`MCA_AN_AUTO]   = auto_on;
		next_annun[`MCA_AN_FIXED]  = ~auto_on;
		next_annun[`MCA_AN_HOLD]   = flags[`MCA_FL_HOLD];
		next_annun[`MCA_AN_OFFS]   = flags[`MCA_FL_OFFS];
		next_annun[`MCA_AN_MAXMIN] = flags[`MCA_FL_MAX] | flags[`MCA_FL_MIN];
		next_annun[`MCA_AN_NANO]   = is_cap & (range <= 3'h1);
		next_annun[`MCA_AN_MICRO1] = is_cap & (range >= 3'h2) & (range <= 3'h4);
		next_annun[`MCA_AN_MILLI1] = is_cap & (range >= 3'h5);
		next_annun[`MCA_AN_MILLI2] = (is_volt & (range == 3'h4)) | (is_curr & (unit == `MCA_UNIT_MA));
		next_annun[`MCA_AN_MICRO2] = is_curr & (unit == `MCA_UNIT_UA);
		next_annun[`MCA_AN_KILO]   = is_ohm & (range >= 3'h1) & (range <= 3'h3);
		next_annun[`MCA_AN_MEGA]   = is_ohm & (range >= 3'h4) & (range <= 3'h6);
		next_annun[`MCA_AN_DEGF]   = is_temp & flags[`MCA_FL_TEMPF];
		next_annun[`MCA_AN_DEGC]   = is_temp & ~flags[`MCA_FL_TEMPF];
		next_annun[`MCA_AN_PWROFF] = flags[`MCA_FL_PWROFF];
		next_annun[`MCA_AN_RS232]  = flags[`MCA_FL_RS232];
	end

	// Annunciators registered so the glass driver sees clean levels
	always @(posedge clk_i) begin
		if (rst_i) begin
			annun_o <= {`MCA_AN_WIDTH{1'b0}};
		end else begin
			annun_o <= next_annun;
		end
	end

	// Register writes, low two byte lanes only
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg   <= `MCA_CFG_RST;
			flags <= `MCA_FLAGS_RST;
		end else if (bus_wr) begin
			case (word)
				`MCA_REG_CFG: begin
					if (wb_sel_i[0]) cfg[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) cfg[9:8] <= wb_dat_i[9:8];
				end
				`MCA_REG_FLAGS: begin
					if (wb_sel_i[0]) flags <= wb_dat_i[7:0];
				end
				default: begin
					// Read-only or unmapped words ignore writes
				end
			endcase
		end
	end

	// Settling flag; a range-change write wins over a stable write
	always @(posedge clk_i) begin
		if (rst_i) begin
			settling <= 1'b0;
		end else if (bus_wr && word == `MCA_REG_CMD && wb_sel_i[0]) begin
			// enter or leave the fast cycle
			if (wb_dat_i[`MCA_CMD_CHANGED]) begin
				settling <= 1'b1;
			end else if (wb_dat_i[`MCA_CMD_STABLE]) begin
				settling <= 1'b0;
			end
		end
	end

	// Read data and ack, one wait state, unmapped reads return zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				case (word)
					`MCA_REG_CFG:    wb_dat_o <= {22'h000000, cfg};
					`MCA_REG_FLAGS:  wb_dat_o <= {24'h000000, flags};
					`MCA_REG_CMD:    wb_dat_o <= 32'h0000_0000;
					`MCA_REG_STATUS: wb_dat_o <= {24'h000000, freq_cycle_o, fast_fr, fast_cv, settling, phase};
					`MCA_REG_ANNUN:  wb_dat_o <= {10'h000, annun_o};
					default:         wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// File: hw/mca_defines.vh
// Purpose: Shared constants of the meter cycle and annunciator control
// Assumes: 50 MHz system clock, 32-bit classic Wishbone register port
// Notes:   Times are kept in ms and turned into cycle counts in the module
`ifndef MCA_DEFINES_VH
`define MCA_DEFINES_VH

// Clock rate in kHz, cycles per millisecond
`define MCA_CLK_KHZ       50000

// Normal conversion phase times in ms
`define MCA_SETTLE_MS     20
`define MCA_ZERO_MS       20
`define MCA_INT_MS        100
`define MCA_RUN_MS        110
// Shortened phase times in ms, continuity and diode
`define MCA_SETTLE_S_MS   4
`define MCA_ZERO_S_MS     4
`define MCA_INT_S_MS      20
`define MCA_RUN_S_MS      22
// Frequency counter cycle times in ms
`define MCA_FR_LOW_MS     500
`define MCA_FR_UP_MS      1050
// Speed-up factors while auto ranging settles
`define MCA_FAST_DIV      5
`define MCA_FREQ_DIV      10

// Register word offsets (byte address bits 4:2)
`define MCA_REG_CFG       3'h0
`define MCA_REG_FLAGS     3'h1
`define MCA_REG_CMD       3'h2
`define MCA_REG_STATUS    3'h3
`define MCA_REG_ANNUN     3'h4

// Mode codes in CFG[3:0]
`define MCA_MODE_VOLT     4'h0
`define MCA_MODE_CURR     4'h1
`define MCA_MODE_OHM      4'h2
`define MCA_MODE_ADP      4'h3
`define MCA_MODE_CONT     4'h4
`define MCA_MODE_DIODE    4'h5
`define MCA_MODE_FREQ     4'h6
`define MCA_MODE_CAP      4'h7
`define MCA_MODE_TEMP     4'h8
// Current unit codes in CFG[9:8]
`define MCA_UNIT_UA       2'h0
`define MCA_UNIT_MA       2'h1
`define MCA_UNIT_A        2'h2

// CFG field positions
`define MCA_CFG_RANGE_LSB 4
`define MCA_CFG_AC        7
`define MCA_CFG_UNIT_LSB  8
// FLAGS bit positions
`define MCA_FL_AUTO       0
`define MCA_FL_HOLD       1
`define MCA_FL_OFFS       2
`define MCA_FL_MAX        3
`define MCA_FL_MIN        4
`define MCA_FL_TEMPF      5
`define MCA_FL_PWROFF     6
`define MCA_FL_RS232      7
// CMD bit positions, write one to act
`define MCA_CMD_CHANGED   0
`define MCA_CMD_STABLE    1

// Annunciator vector bit positions
`define MCA_AN_CONT       0
`define MCA_AN_DIODE      1
`define MCA_AN_HZ         2
`define MCA_AN_FARAD      3
`define MCA_AN_DC         4
`define MCA_AN_AC         5
`define MCA_AN_AUTO       6
`define MCA_AN_FIXED      7
`define MCA_AN_HOLD       8
`define MCA_AN_OFFS       9
`define MCA_AN_MAXMIN     10
`define MCA_AN_MILLI1     11
`define MCA_AN_MICRO1     12
`define MCA_AN_NANO       13
`define MCA_AN_MILLI2     14
`define MCA_AN_MICRO2     15
`define MCA_AN_MEGA       16
`define MCA_AN_KILO       17
`define MCA_AN_DEGC       18
`define MCA_AN_DEGF       19
`define MCA_AN_PWROFF     20
`define MCA_AN_RS232      21
`define MCA_AN_WIDTH      22

// Reset values
`define MCA_CFG_RST       10'h000
`define MCA_FLAGS_RST     8'h01

`endif

// File: tb/mca_ctrl_assertions.sv
// Purpose: Port-level checks of the meter cycle and annunciator block
// Assumes: Bound to mca_ctrl, single clock, synchronous reset
// Notes:   Phase ceilings use the normal lengths, the longest ones
`timescale 1ns/1ns
`include "mca_defines.vh"
module mca_ctrl_assertions #(
	parameter [31:0] P_SETTLE_CYC = 32'h14,
	parameter [31:0] P_ZERO_CYC   = 32'h14,
	parameter [31:0] P_INT_CYC    = 32'h64,
	parameter [31:0] P_RUN_CYC    = 32'h6e
) (
	input wire                     clk_i,
	input wire                     rst_i,
	input wire                     wb_cyc_i,
	input wire                     wb_stb_i,
	input wire                     wb_we_i,
	input wire [4:0]               wb_adr_i,
	input wire [3:0]               wb_sel_i,
	input wire [31:0]              wb_dat_i,
	input wire [31:0]              wb_dat_o,
	input wire                     wb_ack_o,
	input wire                     zero_settle_o,
	input wire                     auto_zero_o,
	input wire                     ramp_up_o,
	input wire                     rundown_o,
	input wire                     conv_done_o,
	input wire                     freq_cycle_o,
	input wire [`MCA_AN_WIDTH-1:0] annun_o
);
	wire [3:0]  ph = {zero_settle_o, auto_zero_o, ramp_up_o, rundown_o}; // Phase vector
	reg  [3:0]  ph_q; // Phase seen at last edge
	reg  [31:0] pc;   // Age of current phase
	// Phase age, restarts when the phase moves on
	always @(posedge clk_i) begin
		if (rst_i) begin
			ph_q <= 4'h8;
			pc   <= 32'h0;
		end else begin
			ph_q <= ph;
			pc   <= (ph != ph_q) ? 32'h1 : pc + 32'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_PHASE_ONEHOT: assert property ($onehot(ph))
		else $error("phase outputs not one-hot");
	AST_SETTLE_TO_ZERO: assert property ($fell(zero_settle_o) |-> auto_zero_o)
		else $error("zero settle not followed by auto zero");
	AST_RAMP_TO_RUN: assert property ($fell(ramp_up_o) |-> rundown_o)
		else $error("ramp not followed by rundown");
	AST_RUN_TO_ZI: assert property ($fell(rundown_o) |-> zero_settle_o ##[0:1] conv_done_o)
		else $error("rundown not followed by zero settle and done");
	// Long-phase ceiling per phase; a stuck counter shows here
	AST_PHASE_MAX: assert property ((ph == ph_q) |-> pc < (zero_settle_o ? P_SETTLE_CYC :
		auto_zero_o ? P_ZERO_CYC : ramp_up_o ? P_INT_CYC : P_RUN_CYC))
		else $error("phase outlasts its length");
	AST_MODE_EXCL: assert property ($onehot0(annun_o[`MCA_AN_FARAD:`MCA_AN_CONT]))
		else $error("two mode symbols lit");
	AST_DC_AC: assert property (!(annun_o[`MCA_AN_DC] && annun_o[`MCA_AN_AC]))
		else $error("DC and AC both lit");
	AST_AUTO_FIXED: assert property (!$past(rst_i) |-> annun_o[`MCA_AN_AUTO] != annun_o[`MCA_AN_FIXED])
		else $error("auto and fixed range symbols disagree");
	AST_CAP_PREFIX: assert property (annun_o[`MCA_AN_FARAD] |->
		$onehot({annun_o[`MCA_AN_MILLI1], annun_o[`MCA_AN_MICRO1], annun_o[`MCA_AN_NANO]}))
		else $error("capacitance prefix not single");
	AST_TEMP_ONE: assert property (!(annun_o[`MCA_AN_DEGC] && annun_o[`MCA_AN_DEGF]))
		else $error("both temperature units lit");
	AST_FREQ_IN_MODE: assert property (freq_cycle_o |-> annun_o[`MCA_AN_HZ])
		else $error("gate pulse outside frequency mode");
	// Main scenarios reached
	cover property (conv_done_o);
	cover property (freq_cycle_o);
	cover property (annun_o[`MCA_AN_FARAD]);
endmodule

// File: tb/mca_front_model.sv
// Purpose: Far-side stand-in timing conversion phases and gate periods
// Assumes: Phase lines one-hot, zero settle in the top bit
// Notes:   A length latches only when its phase or period ends
`timescale 1ns/1ns
module mca_front_model (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [3:0]  phase_i,
	input  wire        fcyc_i,
	output reg  [31:0] lz_o,
	output reg  [31:0] la_o,
	output reg  [31:0] lr_o,
	output reg  [31:0] ld_o,
	output reg  [31:0] lf_o
);
	reg [3:0]  prv; // Phase at last edge
	reg [31:0] cnt; // Cycles in this phase
	reg [31:0] fc;  // Cycles since gate end
	// Phase and gate timers; first lengths after reset are partial
	always @(posedge clk_i) begin
		if (rst_i) begin
			prv <= 4'h8;
			cnt <= 32'h0;
			fc  <= 32'h0;
		end else begin
			prv <= phase_i;
			cnt <= (phase_i != prv) ? 32'h1 : cnt + 32'h1;
			if (phase_i != prv) begin
				case (prv)
					4'h8: lz_o <= cnt;
					4'h4: la_o <= cnt;
					4'h2: lr_o <= cnt;
					default: ld_o <= cnt;
				endcase
			end
			fc <= fcyc_i ? 32'h1 : fc + 32'h1;
			if (fcyc_i) lf_o <= fc;
		end
	end
endmodule

// File: tb/mca_ctrl_tb_top.sv
// Purpose: Register-driven bench for the meter control block
// Assumes: Shortened phase and gate counts set by parameter
// Notes:   Waits skip partial conversions after each change
`timescale 1ns/1ns
module mca_ctrl_tb_top;
	localparam [31:0] ZN = 32'h28, IN = 32'hc8, DI = 32'hdc; // Normal lengths
	localparam [31:0] ZS = 32'hc, IS = 32'h3c, DS = 32'h42;  // Short lengths
	localparam [31:0] FL = 32'h64, FU = 32'hd2;               // Gate periods
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         wb_cyc = 1'b0;
	reg         wb_stb = 1'b0;
	reg         wb_we = 1'b0;
	reg  [4:0]  wb_adr = 5'h0;
	reg  [31:0] wb_dat = 32'h0;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o, zs, az, ru, rd_ph, conv_done_o, freq_cycle_o;
	wire [21:0] annun_o;
	wire [31:0] lz, la, lr, ld, lf; // Measured lengths
	reg  [31:0] rd;                 // Last read data
	reg  [43:0] tbl [0:13];         // Config, flags, expected symbols
	integer     bad_count = 0;
	integer     checked = 0;
	integer     i;
	mca_ctrl #(.P_SETTLE_CYC(ZN), .P_ZERO_CYC(ZN), .P_INT_CYC(IN), .P_RUN_CYC(DI), .P_SETTLE_S_CYC(ZS),
		.P_ZERO_S_CYC(ZS), .P_INT_S_CYC(IS), .P_RUN_S_CYC(DS), .P_FR_LOW_CYC(FL), .P_FR_UP_CYC(FU))
		mca_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .zero_settle_o(zs), .auto_zero_o(az), .ramp_up_o(ru), .rundown_o(rd_ph),
		.conv_done_o(conv_done_o), .freq_cycle_o(freq_cycle_o), .annun_o(annun_o));
	mca_front_model mca_front_model_inst (.clk_i(clk_i), .rst_i(rst_i), .phase_i({zs, az, ru, rd_ph}),
		.fcyc_i(freq_cycle_o), .lz_o(lz), .la_o(la), .lr_o(lr), .ld_o(ld), .lf_o(lf));
	// 50 MHz clock
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	task final_report;
		begin
			$display("checked %0d bad_count %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// A hang counts against the run and ends it
	task tmo;
		begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED at %0t: timeout", $time);
			final_report;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Classic single Wishbone cycle, held until ack is sampled
	task wb(input w, input [4:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clk_i);
			wb_cyc <= 1'b1;
			wb_stb <= 1'b1;
			wb_we  <= w;
			wb_adr <= a;
			wb_dat <= d;
			n = 0;
			while (wb_ack_o !== 1'b1 && n < 20) begin
				@(posedge clk_i);
				n = n + 1;
			end
			if (n >= 20) tmo;
			rd = wb_dat_o;
			wb_cyc <= 1'b0;
			wb_stb <= 1'b0;
		end
	endtask
	// Count done or gate pulses, bounded
	task wait_ev(input f, input integer n);
		integer k;
		begin
			k = 0;
			while (n > 0 && k < 4000) begin
				@(posedge clk_i);
				#1;
				if ((f ? freq_cycle_o : conv_done_o) === 1'b1) n = n - 1;
				k = k + 1;
			end
			if (n > 0) tmo;
		end
	endtask
	task phases(input [31:0] z, input [31:0] r, input [31:0] d);
		begin
			wait_ev(1'b0, 2);
			// Model logs a length one edge after the phase ends
			@(posedge clk_i);
			#1;
			chk(lz, z);
			chk(la, z);
			chk(lr, r);
			chk(ld, d);
		end
	endtask
	task fr(input [31:0] p);
		begin
			wait_ev(1'b1, 2);
			// Let the model log the period between the two pulses
			@(posedge clk_i);
			#1;
			chk(lf, p);
		end
	endtask
	initial begin
		tbl = '{44'h000_01_000050, 44'h0c0_02_0041a0, 44'h001_04_008290, 44'h101_08_004490,
			44'h012_11_020440, 44'h042_40_110080, 44'h004_80_200081, 44'h005_00_000082,
			44'h006_01_000044, 44'h007_00_002088, 44'h027_00_001088, 44'h057_00_000888,
			44'h008_00_040080, 44'h008_20_080080};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset state, read-only and unmapped places
		wb(1'b0, 5'h04, 32'h0);
		chk(rd, 32'h1);
		wb(1'b1, 5'h10, 32'h0);
		wb(1'b1, 5'h14, 32'hffffffff);
		wb(1'b0, 5'h14, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 5'h10, 32'h0);
		chk(rd, 32'h50);
		$display("test reset done");
		for (i = 0; i < 14; i = i + 1) begin
			wb(1'b1, 5'h00, {20'h0, tbl[i][43:32]});
			wb(1'b1, 5'h04, {24'h0, tbl[i][31:24]});
			repeat (2) @(posedge clk_i);
			chk({10'h0, annun_o}, {8'h0, tbl[i][23:0]});
		end
		$display("test symbols done");
		wb(1'b1, 5'h04, 32'h0);
		for (i = 0; i < 6; i = i + 1) begin
			wb(1'b1, 5'h00, i);
			if (i > 3) phases(ZS, IS, DS);
			else phases(ZN, IN, DI);
		end
		$display("test phases done");
		wb(1'b1, 5'h04, 32'h1);
		wb(1'b1, 5'h00, 32'h0);
		wb(1'b1, 5'h08, 32'h1);
		wb(1'b0, 5'h0c, 32'h0);
		chk(rd & 32'h70, 32'h30);
		phases(ZN / 5, IN / 5, DI / 5);
		wb(1'b1, 5'h00, 32'h2);
		phases(ZN / 5, IN / 5, DI / 5);
		wb(1'b1, 5'h00, 32'h80);
		phases(ZN, IN, DI);
		wb(1'b1, 5'h08, 32'h2);
		wb(1'b1, 5'h00, 32'h0);
		phases(ZN, IN, DI);
		$display("test settling done");
		wb(1'b1, 5'h04, 32'h0);
		wb(1'b1, 5'h00, 32'h6);
		fr(FL);
		wb(1'b1, 5'h00, 32'h16);
		fr(FU);
		wb(1'b1, 5'h04, 32'h1);
		wb(1'b1, 5'h08, 32'h1);
		fr(FU / 10);
		$display("test frequency done");
		final_report;
	end
endmodule
bind mca_ctrl mca_ctrl_assertions #(.P_SETTLE_CYC(P_SETTLE_CYC), .P_ZERO_CYC(P_ZERO_CYC), .P_INT_CYC(P_INT_CYC),
	.P_RUN_CYC(P_RUN_CYC)) mca_ctrl_assertions_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .zero_settle_o(zero_settle_o), .auto_zero_o(auto_zero_o),
	.ramp_up_o(ramp_up_o), .rundown_o(rundown_o), .conv_done_o(conv_done_o),
	.freq_cycle_o(freq_cycle_o), .annun_o(annun_o));
